//--- verilog/decode_pkg.sv
// constants and carrier types of the operand and addressing decoder
// assumes one core clock; every user of it names package::item in full
package decode_pkg;

    // ==================================================================
    // register port offsets and values after reset
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    localparam logic [7:0] REGS_OFS = 8'h10;
    localparam logic [7:0] REGS_LAST = 8'h1F;
    localparam logic [3:0] BANK_SELECT_RST = 4'h0;
    localparam logic [1:0] REGBANK_SELECT_RST = 2'h0;
    localparam logic [3:0] REG_RST = 4'h0;

    // ==================================================================
    // data memory banks and operand ranges
    localparam logic [3:0] FLAG_BANK = 4'hF;
    localparam logic [3:0] LOW_BANK = 4'h0;
    localparam logic [3:0] LAST_SELECTABLE = 4'h3;
    localparam logic [7:0] DIRECT_HIGH_FIRST = 8'h80;
    localparam logic [11:0] FMEM_LO_FIRST = 12'hFB0;
    localparam logic [11:0] FMEM_LO_LAST = 12'hFBF;
    localparam logic [11:0] FMEM_HI_FIRST = 12'hFF0;
    localparam logic [11:0] PMEM_FIRST = 12'hFC0;
    localparam logic [14:0] REL_FWD_MIN = 15'h0002;
    localparam logic [14:0] REL_FWD_MAX = 15'h0010;
    localparam logic [14:0] REL_BACK_MIN = 15'h7FF1;
    localparam logic [14:0] PAGE_LAST = 15'h5F7F;
    localparam logic [14:0] ABS_LAST = 15'h3F7F;
    localparam logic [14:0] EXT_LAST = 15'h5F7F;
    localparam logic [14:0] FIX_LAST = 15'h07FF;
    localparam logic [7:0] TABLE_FIRST = 8'h20;
    localparam logic [7:0] TABLE_LAST = 8'h7F;

    // ==================================================================
    // instruction kinds and carriers
    typedef enum logic [4:0] {
        OP_OTHER, OP_LD_A_N4, OP_LD_XA_N8, OP_LD_HL_N8,
        OP_ADD_IMM_SKIP, OP_ADD_CARRY, OP_SUB_BORROW,
        OP_PAIR_ANY, OP_PAIR_RESTRICTED, OP_IND_HL, OP_IND_DE,
        OP_DIRECT4, OP_DIRECT8, OP_FLAG_BIT, OP_PORT_BIT,
        OP_BR_REL, OP_BR_PAGE, OP_CALL_FIXED, OP_TABLE,
        OP_BR_ABS, OP_BR_EXT, OP_SEL_REGBANK, OP_SEL_MEMBANK
    } op_kind_t;

    typedef enum logic [1:0] {
        GRP_NONE, GRP_A, GRP_B
    } load_group_t;

    typedef struct packed {
        op_kind_t kind;
        logic [15:0] operand;
        logic [1:0] bit_pos;
        logic [3:0] mem_data;
        logic [14:0] pc;
        logic [1:0] length;
    } instr_t;

    typedef struct packed {
        logic done;
        logic suppressed;
        logic operand_ok;
        logic skip;
        logic [3:0] acc;
        logic carry_flag;
        logic [3:0] active_data_bank;
        logic [11:0] data_addr;
        logic [14:0] target;
        logic [7:0] pair_value;
        logic [3:0] bit_mask;
    } result_t;

endpackage : decode_pkg

//--- verilog/nib_alu.sv
// four-bit adder and subtractor with carry in and carry or borrow out
// assumes operands from the same clock; purely combinational
`timescale 1ns/1ns
`default_nettype none

module nib_alu (
    input wire logic [3:0] a,
    input wire logic [3:0] b,
    input wire logic cin,
    input wire logic sub,
    output logic [3:0] result,
    output logic cout
);

    logic [4:0] wide;

    always_comb begin
        if (sub) begin
            wide = {1'b0, a} - {1'b0, b} - {4'h0, cin};
        end else begin
            wide = {1'b0, a} + {1'b0, b} + {4'h0, cin};
        end
    end

    assign result = wide[3:0];
    assign cout = wide[4];

endmodule : nib_alu

`default_nettype wire

//--- verilog/bank_map.sv
// picks the data bank an access uses from its addressing kind
// assumes flag and select come straight from core registers
`timescale 1ns/1ns
`default_nettype none

module bank_map (
    input wire decode_pkg::op_kind_t kind,
    input wire logic bank_enable_flag,
    input wire logic [3:0] bank_select_value,
    input wire logic [7:0] addr8,
    output logic [3:0] active_data_bank
);

    always_comb begin
        case (kind)
            decode_pkg::OP_IND_HL:
                active_data_bank = bank_select_value
                    & {4{bank_enable_flag}}; // RULE_09
            decode_pkg::OP_IND_DE:
                active_data_bank = decode_pkg::LOW_BANK; // RULE_10
            decode_pkg::OP_DIRECT4, decode_pkg::OP_DIRECT8: begin
                if (bank_enable_flag) begin
                    active_data_bank = bank_select_value; // RULE_11
                end else if (addr8 >= decode_pkg::DIRECT_HIGH_FIRST) begin
                    active_data_bank = decode_pkg::FLAG_BANK;
                end else begin
                    active_data_bank = decode_pkg::LOW_BANK;
                end
            end
            decode_pkg::OP_FLAG_BIT, decode_pkg::OP_PORT_BIT:
                active_data_bank = decode_pkg::FLAG_BANK; // RULE_12
            default:
                active_data_bank = decode_pkg::LOW_BANK;
        endcase
    end

endmodule : bank_map

`default_nettype wire

//--- verilog/operand_addressing_decode.sv
// decode and address generation for a four-bit core: load suppression,
// radix adjust, pair fields, bank mapping and branch target checks
// assumes instructions arrive one per pulse from logic on core_clk
//
// What this block does
// RULE_01 - consecutive same-group loads: first executes, the rest act as no-ops
// RULE_02 - group A: accumulator nibble and pair loads; group B: address pair load
// RULE_03 - radix add: add 16-m, add memory with carry, add m gives digit
// RULE_04 - radix subtract: subtract with borrow, add m gives complement, borrow in carry
// RULE_05 - software must not use the skip of the final adjust add
// RULE_06 - eight nibble registers form four pairs, plus four extended pairs
// RULE_07 - pair field picks eight pairs; restricted form refuses accumulator pair
// RULE_08 - direct operands are eight bits; byte transfers need even addresses
// RULE_09 - indirect through address pair uses enable AND select as bank
// RULE_10 - indirect through D/E pairs always uses bank zero
// RULE_11 - direct with enable clear: low half bank 0, high half bank 15
// RULE_12 - flag and port bit operands use bank 15 in their ranges
// RULE_13 - relative target lies 15..1 below or 2..16 above the counter
// RULE_14 - page jump keeps counter bits 14..12, last page ends at 5F7F
// RULE_15 - fixed-area call has eleven bits, reaching 0000 to 07FF
// RULE_16 - table operand lies in 20..7F with bit zero clear
// RULE_17 - absolute jump reaches 3F7F, extended absolute reaches 5F7F
// RULE_18 - bit position is two bits selecting one of four
// RULE_19 - four register banks; memory banks 0, 1, 2, 3 and 15 only
// RULE_20 - any other instruction ends a suppression run
`timescale 1ns/1ns
`default_nettype none

module operand_addressing_decode (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic instr_valid,
    input wire decode_pkg::instr_t instr,
    output decode_pkg::result_t result,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [31:0] reg_rdata
);

    // ==================================================================
    // state
    typedef enum logic [1:0] {
        ADJ_NONE, ADJ_AFTER_ADD, ADJ_AFTER_SUB
    } adjust_t;

    typedef struct packed {
        logic [15:0][3:0] regs;
        logic bank_enable_flag;
        logic [3:0] bank_select_value;
        logic regbank_enable_flag;
        logic [1:0] regbank_select_value;
        logic carry_flag;
        decode_pkg::load_group_t last_group;
        logic [14:0] expect_pc;
        adjust_t adjust;
        logic [31:0] rdata;
        decode_pkg::result_t res;
    } state_t;

    state_t state_q;
    state_t state_d;

    decode_pkg::load_group_t group;
    logic suppress;
    logic [3:0] alu_b;
    logic alu_cin;
    logic alu_sub;
    logic [3:0] alu_sum;
    logic alu_cout;
    logic [3:0] bank;
    logic [2:0] pair_sel;
    logic [7:0] pair_value;
    logic [14:0] rel_diff;
    logic [14:0] page_target;
    logic [11:0] flag_addr;
    logic adjust_add_on;
    logic bank_ok;

    // ==================================================================
    // shared arithmetic and bank lookup
    nib_alu alu (
        .a(state_q.regs[0]),
        .b(alu_b),
        .cin(alu_cin),
        .sub(alu_sub),
        .result(alu_sum),
        .cout(alu_cout)
    );

    bank_map banks (
        .kind(instr.kind),
        .bank_enable_flag(state_q.bank_enable_flag),
        .bank_select_value(state_q.bank_select_value),
        .addr8(instr.operand[7:0]),
        .active_data_bank(bank)
    );

    // ==================================================================
    // operand decoding
    always_comb begin
        case (instr.kind)
            decode_pkg::OP_LD_A_N4, decode_pkg::OP_LD_XA_N8:
                group = decode_pkg::GRP_A; // RULE_02
            decode_pkg::OP_LD_HL_N8:
                group = decode_pkg::GRP_B; // RULE_02
            default:
                group = decode_pkg::GRP_NONE;
        endcase
    end

    // a run only counts when the load sits right after its predecessor
    assign suppress = (group != decode_pkg::GRP_NONE)
        && (group == state_q.last_group)
        && (instr.pc == state_q.expect_pc); // RULE_01

    // the final add of an adjust pair only corrects when it is needed
    always_comb begin
        case (state_q.adjust)
            ADJ_AFTER_ADD: adjust_add_on = !state_q.carry_flag; // RULE_03
            ADJ_AFTER_SUB: adjust_add_on = state_q.carry_flag; // RULE_04
            default: adjust_add_on = 1'b1;
        endcase
    end

    always_comb begin
        alu_sub = (instr.kind == decode_pkg::OP_SUB_BORROW);
        if (instr.kind == decode_pkg::OP_ADD_IMM_SKIP) begin
            alu_b = adjust_add_on ? instr.operand[3:0] : 4'h0;
            alu_cin = 1'b0;
        end else begin
            alu_b = instr.mem_data;
            alu_cin = state_q.carry_flag;
        end
    end

    // codes 0..3 normal pairs, 4..7 extended pairs at registers 8..15
    assign pair_sel = instr.operand[2:0]; // RULE_06
    assign pair_value = {state_q.regs[{pair_sel, 1'b1}],
        state_q.regs[{pair_sel, 1'b0}]}; // RULE_07

    assign rel_diff = instr.operand[14:0] - instr.pc;
    assign page_target = {instr.pc[14:12], instr.operand[11:0]}; // RULE_14
    assign flag_addr = instr.operand[11:0];
    assign bank_ok = (instr.operand[3:0] <= decode_pkg::LAST_SELECTABLE)
        || (instr.operand[3:0] == decode_pkg::FLAG_BANK); // RULE_19

    // ==================================================================
    // next state
    always_comb begin
        state_d = state_q;
        state_d.res.done = 1'b0;
        state_d.rdata = 32'h0000_0000;

        if (reg_write) begin
            if (reg_addr == decode_pkg::CTRL_OFS) begin
                state_d.bank_enable_flag = reg_wdata[0];
                state_d.regbank_enable_flag = reg_wdata[1];
                state_d.regbank_select_value = reg_wdata[5:4];
                // reserved bank numbers are refused, old value stays
                if ((reg_wdata[11:8] <= decode_pkg::LAST_SELECTABLE)
                        || (reg_wdata[11:8] == decode_pkg::FLAG_BANK)) begin
                    state_d.bank_select_value = reg_wdata[11:8]; // RULE_19
                end
            end else if (reg_addr >= decode_pkg::REGS_OFS
                    && reg_addr <= decode_pkg::REGS_LAST) begin
                state_d.regs[reg_addr[3:0]] = reg_wdata[3:0];
            end
        end

        if (reg_read) begin
            if (reg_addr == decode_pkg::CTRL_OFS) begin
                state_d.rdata = {20'h00000, state_q.bank_select_value,
                    2'h0, state_q.regbank_select_value, 2'h0,
                    state_q.regbank_enable_flag, state_q.bank_enable_flag};
            end else if (reg_addr == decode_pkg::STATUS_OFS) begin
                state_d.rdata = {22'h000000, state_q.last_group,
                    3'h0, state_q.carry_flag, state_q.regs[0]};
            end else if (reg_addr >= decode_pkg::REGS_OFS
                    && reg_addr <= decode_pkg::REGS_LAST) begin
                state_d.rdata = {28'h0000000, state_q.regs[reg_addr[3:0]]};
            end
        end

        if (instr_valid) begin
            state_d.res.done = 1'b1;
            state_d.res.suppressed = suppress;
            state_d.res.operand_ok = 1'b1;
            state_d.res.skip = 1'b0;
            state_d.res.active_data_bank = bank;
            state_d.res.data_addr = {bank, instr.operand[7:0]};
            state_d.res.target = instr.operand[14:0];
            state_d.res.pair_value = pair_value;
            state_d.res.bit_mask = 4'h1 << instr.bit_pos; // RULE_18
            state_d.last_group = group; // RULE_20
            state_d.expect_pc = instr.pc + {13'h0000, instr.length};
            state_d.adjust = ADJ_NONE;

            case (instr.kind)
                decode_pkg::OP_LD_A_N4: begin
                    if (!suppress) begin
                        state_d.regs[0] = instr.operand[3:0]; // RULE_01
                    end
                end
                decode_pkg::OP_LD_XA_N8: begin
                    if (!suppress) begin
                        state_d.regs[0] = instr.operand[3:0]; // RULE_01
                        state_d.regs[1] = instr.operand[7:4];
                    end
                end
                decode_pkg::OP_LD_HL_N8: begin
                    if (!suppress) begin
                        state_d.regs[6] = instr.operand[3:0]; // RULE_01
                        state_d.regs[7] = instr.operand[7:4];
                    end
                end
                decode_pkg::OP_ADD_IMM_SKIP: begin
                    state_d.regs[0] = alu_sum; // RULE_03
                    // the skip is withheld inside an adjust pair
                    state_d.res.skip = alu_cout
                        && (state_q.adjust == ADJ_NONE); // RULE_05
                end
                decode_pkg::OP_ADD_CARRY: begin
                    state_d.regs[0] = alu_sum; // RULE_03
                    state_d.carry_flag = alu_cout;
                    state_d.adjust = ADJ_AFTER_ADD;
                end
                decode_pkg::OP_SUB_BORROW: begin
                    state_d.regs[0] = alu_sum; // RULE_04
                    state_d.carry_flag = alu_cout;
                    state_d.adjust = ADJ_AFTER_SUB;
                end
                decode_pkg::OP_PAIR_RESTRICTED:
                    state_d.res.operand_ok = (pair_sel != 3'h0); // RULE_07
                decode_pkg::OP_IND_HL:
                    state_d.res.data_addr = {bank, state_q.regs[7],
                        state_q.regs[6]}; // RULE_09
                decode_pkg::OP_IND_DE:
                    // operand bit 0 picks D with L instead of D with E
                    state_d.res.data_addr = {bank, state_q.regs[5],
                        instr.operand[0] ? state_q.regs[6]
                                         : state_q.regs[4]}; // RULE_10
                decode_pkg::OP_DIRECT8:
                    state_d.res.operand_ok = !instr.operand[0]; // RULE_08
                decode_pkg::OP_FLAG_BIT: begin
                    state_d.res.data_addr = flag_addr; // RULE_12
                    state_d.res.operand_ok = (flag_addr
                        >= decode_pkg::FMEM_LO_FIRST && flag_addr
                        <= decode_pkg::FMEM_LO_LAST) || (flag_addr
                        >= decode_pkg::FMEM_HI_FIRST); // RULE_12
                end
                decode_pkg::OP_PORT_BIT: begin
                    state_d.res.data_addr = flag_addr; // RULE_12
                    state_d.res.operand_ok =
                        (flag_addr >= decode_pkg::PMEM_FIRST); // RULE_12
                end
                decode_pkg::OP_BR_REL:
                    state_d.res.operand_ok =
                        (rel_diff >= decode_pkg::REL_FWD_MIN
                        && rel_diff <= decode_pkg::REL_FWD_MAX)
                        || (rel_diff >= decode_pkg::REL_BACK_MIN); // RULE_13
                decode_pkg::OP_BR_PAGE: begin
                    state_d.res.target = page_target; // RULE_14
                    state_d.res.operand_ok =
                        (page_target <= decode_pkg::PAGE_LAST); // RULE_14
                end
                decode_pkg::OP_CALL_FIXED: begin
                    state_d.res.target = {4'h0, instr.operand[10:0]}; // RULE_15
                    state_d.res.operand_ok = (instr.operand[15:11] == 5'h00)
                        && (instr.operand[14:0]
                        <= decode_pkg::FIX_LAST); // RULE_15
                end
                decode_pkg::OP_TABLE:
                    state_d.res.operand_ok = !instr.operand[0]
                        && instr.operand[15:8] == 8'h00
                        && instr.operand[7:0] >= decode_pkg::TABLE_FIRST
                        && instr.operand[7:0]
                        <= decode_pkg::TABLE_LAST; // RULE_16
                decode_pkg::OP_BR_ABS:
                    state_d.res.operand_ok = (instr.operand[14:0]
                        <= decode_pkg::ABS_LAST); // RULE_17
                decode_pkg::OP_BR_EXT:
                    state_d.res.operand_ok = (instr.operand[14:0]
                        <= decode_pkg::EXT_LAST); // RULE_17
                decode_pkg::OP_SEL_REGBANK:
                    state_d.regbank_select_value = instr.operand[1:0]; // RULE_19
                decode_pkg::OP_SEL_MEMBANK: begin
                    state_d.res.operand_ok = bank_ok; // RULE_19
                    if (bank_ok) begin
                        state_d.bank_select_value = instr.operand[3:0];
                    end
                end
                default: begin
                end
            endcase
            state_d.res.acc = state_d.regs[0];
            state_d.res.carry_flag = state_d.carry_flag;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_q <= '0;
            state_q.bank_select_value <= decode_pkg::BANK_SELECT_RST;
            state_q.regbank_select_value <= decode_pkg::REGBANK_SELECT_RST;
            state_q.regs <= {16{decode_pkg::REG_RST}};
            state_q.last_group <= decode_pkg::GRP_NONE;
            state_q.adjust <= ADJ_NONE;
        end else begin
            state_q <= state_d;
        end
    end

    assign result = state_q.res;
    assign reg_rdata = state_q.rdata;

    // ==================================================================
    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    second_load_nop_a: assert property ( // RULE_01
        instr_valid && group != decode_pkg::GRP_NONE
        && group == state_q.last_group && instr.pc == state_q.expect_pc
        |=> result.suppressed && $stable(state_q.regs[0]))
        else $error("repeated group load was not suppressed");

    run_break_a: assert property ( // RULE_20
        instr_valid && group != decode_pkg::GRP_NONE
        && group != state_q.last_group |=> !result.suppressed)
        else $error("load after a break was suppressed");

    add_carry_a: assert property ( // RULE_03
        instr_valid && instr.kind == decode_pkg::OP_ADD_CARRY
        |=> result.carry_flag == (({1'b0, $past(state_q.regs[0])}
        + {1'b0, $past(instr.mem_data)}
        + {4'h0, $past(state_q.carry_flag)}) > 5'h0F))
        else $error("carry after add with carry is wrong");

    sub_borrow_a: assert property ( // RULE_04
        instr_valid && instr.kind == decode_pkg::OP_SUB_BORROW
        |=> result.carry_flag == ({1'b0, $past(state_q.regs[0])}
        < {1'b0, $past(instr.mem_data)}
        + {4'h0, $past(state_q.carry_flag)}))
        else $error("borrow after subtract is wrong");

    adjust_skip_a: assert property ( // RULE_05
        state_q.adjust != ADJ_NONE && instr_valid
        && instr.kind == decode_pkg::OP_ADD_IMM_SKIP |=> !result.skip)
        else $error("skip raised inside adjust pair");

    indirect_bank_a: assert property ( // RULE_09
        instr_valid && instr.kind == decode_pkg::OP_IND_HL
        && !state_q.bank_enable_flag |=> result.active_data_bank == 4'h0)
        else $error("bank used while bank enable is clear");

    de_bank_a: assert property ( // RULE_10
        instr_valid && instr.kind == decode_pkg::OP_IND_DE
        |=> result.active_data_bank == 4'h0)
        else $error("pair access left bank zero");

    direct_high_a: assert property ( // RULE_11
        instr_valid && instr.kind == decode_pkg::OP_DIRECT4
        && !state_q.bank_enable_flag && instr.operand[7]
        |=> result.data_addr[11:8] == 4'hF)
        else $error("upper direct half not in bank 15");

    odd_byte_a: assert property ( // RULE_08
        instr_valid && instr.kind == decode_pkg::OP_DIRECT8
        && instr.operand[0] |=> !result.operand_ok)
        else $error("odd byte address accepted");

    bank_legal_a: assert property ( // RULE_19
        state_q.bank_select_value <= 4'h3
        || state_q.bank_select_value == 4'hF)
        else $error("reserved memory bank selected");

endmodule : operand_addressing_decode

`default_nettype wire

//--- sim/operand_addressing_decode_tb.sv
// bench for the decoder: fixed expected values and a radix model are checked at chosen results
// assumes decode_pkg is compiled first; the bench drives every port
`timescale 1ns/1ns
`default_nettype none
module operand_addressing_decode_tb;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic instr_valid = 1'b0;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic [31:0] reg_rdata;
    decode_pkg::instr_t instr = '0;
    decode_pkg::result_t res;
    logic [1:0] bp = 2'h0;
    logic [1:0] len = 2'h1;
    // kind, ok flag, operand
    logic [31:0] t [11] = '{32'h1301_3F7F, 32'h1300_3F80, 32'h1401_5F7F,
        32'h1400_5F80, 32'h1101_07FF, 32'h1100_0800, 32'h1201_0020,
        32'h1200_001E, 32'h1201_007E, 32'h1200_007F, 32'h1200_0080};
    int fails = 0, checked = 0, seed = 32'h178F, a, b, c = 0, e, m, i;
    wire logic [19:0] bam = {res.active_data_bank, res.data_addr, res.bit_mask};
    operand_addressing_decode i_dut (.core_clk(core_clk), .rst(rst),
        .instr_valid(instr_valid), .instr(instr), .result(res),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_read(reg_read), .reg_rdata(reg_rdata));
    // ====================
    // bus and compare tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        checked++;
        if (seen !== want) begin
            fails++;
            $display("BAD %0t seen %h want %h", $time, seen, want);
        end
    endtask : chk
    // kinds by enum position: 1 nibble load, 4 add imm, 9 via address pair
    task automatic op(input int k, input logic [15:0] o,
                      input logic [14:0] p, input logic [3:0] md = 4'h0);
        @(posedge core_clk);
        instr_valid <= 1'b1;
        instr <= '{decode_pkg::op_kind_t'(k), o, bp, md, p, len};
        @(posedge core_clk);
        instr_valid <= 1'b0;
        #1 chk(res.done, 1'b1);
    endtask : op
    task automatic wr(input logic [7:0] ad, input logic [31:0] d);
        @(posedge core_clk);
        reg_write <= 1'b1;
        reg_addr <= ad;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_write <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] ad, input logic [31:0] want);
        @(posedge core_clk);
        reg_read <= 1'b1;
        reg_addr <= ad;
        @(posedge core_clk);
        reg_read <= 1'b0;
        #1 chk(reg_rdata, want);
    endtask : rd
    task automatic summarize;
        $display("compares %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : summarize
    initial begin
        forever #25 core_clk = ~core_clk;
    end
    // hang guard, well past the longest sequence
    initial begin
        repeat (50000) @(posedge core_clk);
        fails++;
        summarize();
    end
    // ====================
    // scenarios
    initial begin
        repeat (16) @(posedge core_clk);
        rst <= 1'b0;
        rd(8'h00, 32'h0);
        op(1, 16'h0005, 15'h0010);
        chk({res.suppressed, res.acc}, 5'h05);
        len = 2'h2;
        op(2, 16'h0037, 15'h0011);
        chk({res.suppressed, res.acc}, 5'h15);
        op(3, 16'h009A, 15'h0013);
        chk(res.suppressed, 1'b0);
        op(3, 16'h009A, 15'h0015);
        chk(res.suppressed, 1'b1);
        op(0, 16'h0000, 15'h0017);
        op(3, 16'h009A, 15'h0019);
        chk(res.suppressed, 1'b0);
        len = 2'h1;
        $display("load run test done");
        for (i = 0; i < 16; i++) begin
            m = 2 + {$random(seed)} % 14;
            a = {$random(seed)} % m;
            b = {$random(seed)} % m;
            op(1, 16'(a), 15'h0200);
            if (i[0]) begin
                op(6, 16'h0, 15'h0201, 4'(b));
                e = a - b - c;
                c = e < 0 ? 1 : 0;
                e = e + c * m;
            end else begin
                op(4, 16'(16 - m), 15'h0201);
                op(5, 16'h0, 15'h0202, 4'(b));
                e = a + b + c;
                c = e >= m ? 1 : 0;
                e = e - c * m;
            end
            op(4, 16'(m), 15'h0203);
            chk({res.skip, res.carry_flag, res.acc}, c * 16 + e);
        end
        op(1, 16'h0009, 15'h0210);
        op(4, 16'h0008, 15'h0211);
        chk({res.skip, res.carry_flag, res.acc}, c * 16 + 'h21);
        $display("radix test done");
        for (i = 0; i < 5; i++) begin
            m = i < 4 ? i : 15;
            wr(8'h00, 32'(m * 256 + 1));
            op(9, 16'h0, 15'h0300);
            chk(res.active_data_bank, m);
            op(10, 16'h0001, 15'h0301);
            chk(res.active_data_bank, 4'h0);
            op(11, 16'h0085, 15'h0302);
            chk(bam[19:4], m * 4096 + m * 256 + 'h85);
        end
        wr(8'h00, 32'h0501);
        op(9, 16'h0, 15'h0300);
        chk(res.active_data_bank, 4'hF);
        wr(8'h00, 32'h0F00);
        op(9, 16'h0, 15'h0300);
        chk(res.active_data_bank, 4'h0);
        op(11, 16'h007F, 15'h0302);
        chk(bam[19:4], 16'h007F);
        op(11, 16'h0080, 15'h0302);
        chk(bam[19:4], 16'hFF80);
        for (i = 0; i < 4; i++) begin
            bp = 2'(i);
            op(13, 16'h0FB3, 15'h0303);
            chk(bam, 'hFFB30 + (1 << i));
        end
        op(12, 16'h0085, 15'h0306);
        chk(res.operand_ok, 1'b0);
        op(12, 16'h0084, 15'h0306);
        chk(res.operand_ok, 1'b1);
        op(14, 16'h0FC5, 15'h0304);
        chk(bam[19:4], 16'hFFC5);
        op(22, 16'h0005, 15'h0305);
        chk(res.operand_ok, 1'b0);
        op(22, 16'h000F, 15'h0305);
        chk(res.operand_ok, 1'b1);
        $display("bank test done");
        for (i = -16; i < 18; i++) begin
            op(15, 16'(256 + i), 15'h0100);
            chk(res.operand_ok, i inside {[-15:-1], [2:16]});
        end
        for (i = 0; i < 11; i++) begin
            op(int'(t[i][31:24]), t[i][15:0], 15'h0100);
            chk(res.operand_ok, t[i][16]);
        end
        op(16, 16'h0ABC, 15'h2345);
        chk({res.operand_ok, res.target}, 16'hAABC);
        op(16, 16'h0F80, 15'h5000);
        chk(res.operand_ok, 1'b0);
        $display("target test done");
        for (i = 0; i < 16; i++) wr(8'(16 + i), 32'(i));
        for (i = 0; i < 8; i++) begin
            op(7, 16'(i), 15'h0400);
            chk({res.operand_ok, res.pair_value}, 'h100 + 34 * i + 16);
        end
        op(8, 16'h0000, 15'h0400);
        chk(res.operand_ok, 1'b0);
        rd(8'h13, 32'h3);
        rd(8'h04, 32'(c * 16));
        rd(8'h08, 32'h0);
        $display("pair test done");
        summarize();
    end
endmodule : operand_addressing_decode_tb
`default_nettype wire
